// >>> core/fas_host.sv
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "fas_defines.svh"
module fas_host (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // device bus
  fas_bus_if.host         bus,
  // software port
  input  wire logic [3:0] u_addr,
  input  wire logic [7:0] u_wdata,
  input  wire logic       u_wr,
  input  wire logic       u_rd,
  output logic      [7:0] u_rdata,
  output logic            irq
);
  import fas_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  fas_hop_type hop_r,    hop_nxt;
  fas_hst_type hst_r,    hst_nxt;
  logic [2:0]  step_r,   step_nxt;
  logic [15:0] ptr_r,    ptr_nxt;
  logic [7:0]  data_r,   data_nxt;
  logic [2:0]  int_r,    int_nxt;
  logic [2:0]  mask_r,   mask_nxt;
  logic [7:0]  urd_r,    urd_nxt;
  logic [7:0]  baddr_r,  baddr_nxt;
  logic [7:0]  bwdat_r,  bwdat_nxt;
  logic        bwr_r,    bwr_nxt;
  logic        brd_r,    brd_nxt;
  logic        rvld_r;
  logic [2:0]  ev;
  fas_step_type st;

  // fixed access script per operation
  function automatic fas_step_type step_of(
    input fas_hop_type hop,
    input logic [2:0]  idx
  );
    fas_step_type s;
    s = '{acc: ACC_END, addr: `FAS_ZERO8, dsel: D_DATA};
    case ({hop, idx})
      {HOP_READ, 3'h0}, {HOP_PROG, 3'h0}, {HOP_WIPE, 3'h0}:
        s = '{acc: ACC_WR, addr: `FAS_REG_PTRL, dsel: D_PTRL};
      {HOP_READ, 3'h1}, {HOP_PROG, 3'h1}, {HOP_WIPE, 3'h1}:
        s = '{acc: ACC_WR, addr: `FAS_REG_PTRH, dsel: D_PTRH};
      {HOP_READ, 3'h2}, {HOP_PROG, 3'h2}:
        s = '{acc: ACC_RD, addr: `FAS_REG_BYTE, dsel: D_DATA};
      {HOP_READ, 3'h3}, {HOP_SEQ, 3'h1}:
        s = '{acc: ACC_CAP, addr: `FAS_ZERO8, dsel: D_DATA};
      {HOP_SEQ, 3'h0}:
        s = '{acc: ACC_RD, addr: `FAS_REG_AUTORD, dsel: D_DATA};
      {HOP_PROG, 3'h3}:
        s = '{acc: ACC_CHK, addr: `FAS_ZERO8, dsel: D_DATA};
      {HOP_PROG, 3'h4}, {HOP_WIPE, 3'h2}:
        s = '{acc: ACC_WR, addr: `FAS_REG_KEY, dsel: D_KEY1};
      {HOP_PROG, 3'h5}, {HOP_WIPE, 3'h3}:
        s = '{acc: ACC_WR, addr: `FAS_REG_KEY, dsel: D_KEY2};
      {HOP_PROG, 3'h6}:
        s = '{acc: ACC_WR, addr: `FAS_REG_BYTE, dsel: D_DATA};
      {HOP_WIPE, 3'h4}:
        s = '{acc: ACC_WR, addr: `FAS_REG_WIPE, dsel: D_GO};
      default: s = '{acc: ACC_END, addr: `FAS_ZERO8, dsel: D_DATA};
    endcase
    return s;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    hop_nxt   = hop_r;
    hst_nxt   = hst_r;
    step_nxt  = step_r;
    ptr_nxt   = ptr_r;
    data_nxt  = data_r;
    mask_nxt  = mask_r;
    urd_nxt   = `FAS_ZERO8;
    baddr_nxt = baddr_r;
    bwdat_nxt = bwdat_r;
    bwr_nxt   = 1'b0;
    brd_nxt   = 1'b0;
    ev        = 3'h0;
    st        = step_of(hop_r, step_r);

    ev[`FAS_INT_DONE] = bus.op_done;

    case (hst_r)
      HS_RUN: begin
        case (st.acc)
          ACC_WR: begin
            bwr_nxt   = 1'b1;
            baddr_nxt = st.addr;
            step_nxt  = step_r + 3'h1;
            case (st.dsel)
              D_PTRL:  bwdat_nxt = ptr_r[7:0];
              D_PTRH:  bwdat_nxt = ptr_r[15:8];
              D_KEY1:  bwdat_nxt = `FAS_KEY1;
              D_KEY2:  bwdat_nxt = `FAS_KEY2;
              D_GO:    bwdat_nxt = `FAS_WIPE_GO;
              default: bwdat_nxt = data_r;
            endcase
          end
          ACC_RD: begin
            brd_nxt   = 1'b1;
            baddr_nxt = st.addr;
            step_nxt  = step_r + 3'h1;
          end
          ACC_CAP: begin
            if (rvld_r) begin
              data_nxt        = bus.rdata;
              ev[`FAS_INT_RD] = 1'b1;
              hst_nxt         = HS_IDLE;
            end
          end
          ACC_CHK: begin
            if (rvld_r) begin
              if (bus.rdata != `FAS_ERASED) begin
                ev[`FAS_INT_REFUSE] = 1'b1;
                hst_nxt             = HS_IDLE;
              end else begin
                step_nxt = step_r + 3'h1;
              end
            end
          end
          default: hst_nxt = HS_WAIT;
        endcase
      end
      HS_WAIT: begin
        if (bus.op_done) begin
          hst_nxt = HS_IDLE;
        end
      end
      default: begin
        if (u_wr && u_addr == `FAS_H_CMD) begin
          hop_nxt  = fas_hop_type'(u_wdata[1:0]);
          hst_nxt  = HS_RUN;
          step_nxt = 3'h0;
        end
      end
    endcase

    // software operand writes only take effect while idle
    if (u_wr && hst_r == HS_IDLE) begin
      case (u_addr)
        `FAS_H_PTRL: ptr_nxt[7:0]  = u_wdata;
        `FAS_H_PTRH: ptr_nxt[15:8] = u_wdata;
        `FAS_H_DATA: data_nxt      = u_wdata;
        default: ;
      endcase
    end
    if (u_wr && u_addr == `FAS_H_MASK) begin
      mask_nxt = u_wdata[2:0];
    end

    // a new event beats a write-one clear in the same cycle
    int_nxt = int_r;
    if (u_wr && u_addr == `FAS_H_INT) begin
      int_nxt = int_r & ~u_wdata[2:0];
    end
    int_nxt = int_nxt | ev;

    if (u_rd) begin
      case (u_addr)
        `FAS_H_PTRL: urd_nxt = ptr_r[7:0];
        `FAS_H_PTRH: urd_nxt = ptr_r[15:8];
        `FAS_H_DATA: urd_nxt = data_r;
        `FAS_H_STAT: urd_nxt = {7'h00, hst_r != HS_IDLE};
        `FAS_H_INT:  urd_nxt = {5'h00, int_r};
        `FAS_H_MASK: urd_nxt = {5'h00, mask_r};
        default:     urd_nxt = `FAS_ZERO8;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hop_r   <= HOP_READ;
      hst_r   <= HS_IDLE;
      step_r  <= 3'h0;
      ptr_r   <= 16'h0000;
      data_r  <= `FAS_ZERO8;
      int_r   <= 3'h0;
      mask_r  <= 3'h0;
      urd_r   <= `FAS_ZERO8;
      baddr_r <= `FAS_ZERO8;
      bwdat_r <= `FAS_ZERO8;
      bwr_r   <= 1'b0;
      brd_r   <= 1'b0;
      rvld_r  <= 1'b0;
    end else begin
      hop_r   <= hop_nxt;
      hst_r   <= hst_nxt;
      step_r  <= step_nxt;
      ptr_r   <= ptr_nxt;
      data_r  <= data_nxt;
      int_r   <= int_nxt;
      mask_r  <= mask_nxt;
      urd_r   <= urd_nxt;
      baddr_r <= baddr_nxt;
      bwdat_r <= bwdat_nxt;
      bwr_r   <= bwr_nxt;
      brd_r   <= brd_nxt;
      rvld_r  <= brd_r;
    end
  end

  assign bus.addr  = baddr_r;
  assign bus.wdata = bwdat_r;
  assign bus.wr    = bwr_r;
  assign bus.rd    = brd_r;
  assign u_rdata   = urd_r;
  assign irq       = |(int_r & mask_r);
endmodule
`default_nettype wire

// >>> core/fas_defines.svh
// What this block does
// - reads complete within one bus cycle
// - byte port read returns byte, pointer unchanged
// - sequential port read returns byte, pointer plus one
// - pointer from high and low byte registers
// - byte port write programs byte when unlocked
// - host programs only bytes reading erased
// - unlock needs key A5 then F1
// - one unlock allows one operation only
// - unlock key register reads as zero
// - wipe bit erases 512-byte page when unlocked
// - wipe register upper bits zero, reserved zero
// - busy status bit while operation runs
// - last operation program or wipe bits
// - status upper bits zero, bit two reserved
// - completion signalled, host waits for it
// - attempt without unlock while idle locks until reset
// - operations timed internally, bus stays served
// - host programs each byte once per erase
`ifndef FAS_DEFINES_SVH
`define FAS_DEFINES_SVH

// ----------------------------------------------------------------
// device register offsets
// ----------------------------------------------------------------
`define FAS_REG_AUTORD 8'h05
`define FAS_REG_BYTE   8'h06
`define FAS_REG_KEY    8'h67
`define FAS_REG_PTRL   8'h68
`define FAS_REG_PTRH   8'h69
`define FAS_REG_WIPE   8'h6A
`define FAS_REG_STAT   8'h7B

// ----------------------------------------------------------------
// fields and values
// ----------------------------------------------------------------
`define FAS_KEY1       8'hA5
`define FAS_KEY2       8'hF1
`define FAS_ERASED     8'hFF
`define FAS_ZERO8      8'h00
`define FAS_WIPE_GO    8'h01
`define FAS_GO_BIT     0
`define FAS_ST_BUSY    3
`define FAS_ST_PROG    1
`define FAS_ST_WIPE    0
`define FAS_MEM_BYTES  8192
`define FAS_MEM_AW     13
`define FAS_PAGE_AW    9
`define FAS_PAGE_BYTES 17'h0_0200
`define FAS_PTR_ONE    16'h0001

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FAS_CLK_NS     100
`define FAS_PROG_NS    55000
`define FAS_ERASE_NS   11000000
`define FAS_PROG_CYC   (`FAS_PROG_NS / `FAS_CLK_NS)
`define FAS_ERASE_CYC  (`FAS_ERASE_NS / `FAS_CLK_NS)

// ----------------------------------------------------------------
// host controller registers
// ----------------------------------------------------------------
`define FAS_H_CMD      4'h0
`define FAS_H_PTRL     4'h1
`define FAS_H_PTRH     4'h2
`define FAS_H_DATA     4'h3
`define FAS_H_STAT     4'h4
`define FAS_H_INT      4'h5
`define FAS_H_MASK     4'h6
`define FAS_INT_DONE   0
`define FAS_INT_RD     1
`define FAS_INT_REFUSE 2

`endif

// >>> core/fas_pkg.sv
`include "fas_defines.svh"
package fas_pkg;
  typedef enum logic [1:0] {
    KEY_SHUT = 2'b00,
    KEY_HALF = 2'b01,
    KEY_OPEN = 2'b10
  } fas_key_type;

  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_PROG = 2'b01,
    OP_WIPE = 2'b10
  } fas_op_type;

  typedef enum logic [1:0] {
    HOP_READ = 2'b00,
    HOP_SEQ  = 2'b01,
    HOP_PROG = 2'b10,
    HOP_WIPE = 2'b11
  } fas_hop_type;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_RUN  = 2'b01,
    HS_WAIT = 2'b10
  } fas_hst_type;

  typedef enum logic [2:0] {
    ACC_WR  = 3'b000,
    ACC_RD  = 3'b001,
    ACC_CHK = 3'b010,
    ACC_CAP = 3'b011,
    ACC_END = 3'b100
  } fas_acc_type;

  typedef enum logic [2:0] {
    D_PTRL = 3'b000,
    D_PTRH = 3'b001,
    D_KEY1 = 3'b010,
    D_KEY2 = 3'b011,
    D_DATA = 3'b100,
    D_GO   = 3'b101
  } fas_dsel_type;

  typedef struct packed {
    fas_acc_type  acc;
    logic [7:0]   addr;
    fas_dsel_type dsel;
  } fas_step_type;
endpackage

// >>> core/fas_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fas_bus_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       op_done;

  modport dev (
    input  addr,
    input  wdata,
    input  wr,
    input  rd,
    output rdata,
    output op_done
  );

  modport host (
    output addr,
    output wdata,
    output wr,
    output rd,
    input  rdata,
    input  op_done
  );
endinterface
`default_nettype wire

// >>> core/fas_device.sv
`timescale 1ns/1ps
`default_nettype none
`include "fas_defines.svh"
module fas_device #(
  parameter int unsigned PROG_CYCLES  = `FAS_PROG_CYC,
  parameter int unsigned ERASE_CYCLES = `FAS_ERASE_CYC
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // host bus
  fas_bus_if.dev    bus,
  // status view
  output logic      nvm_op_in_progress,
  output logic      nvm_locked_out
);
  import fas_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]            mem_r [0:`FAS_MEM_BYTES-1];
  logic                  mem_we;
  logic [`FAS_MEM_AW-1:0] mem_wa;
  logic [7:0]            mem_wd;

  logic [15:0]           ptr_r,       ptr_nxt;
  fas_key_type           key_r,       key_nxt;
  fas_op_type            op_r,        op_nxt;
  logic [16:0]           cnt_r,       cnt_nxt;
  logic [`FAS_MEM_AW-1:0] op_addr_r,  op_addr_nxt;
  logic [7:0]            op_data_r,   op_data_nxt;
  logic                  last_prog_r, last_prog_nxt;
  logic                  last_wipe_r, last_wipe_nxt;
  logic                  lock_r,      lock_nxt;
  logic [7:0]            rdata_r,     rdata_nxt;
  logic                  done_r,      done_nxt;

  logic [7:0]            cur_byte;
  logic                  try_prog;
  logic                  try_wipe;

  function automatic logic [7:0] status_byte(
    input logic busy,
    input logic prog,
    input logic wipe
  );
    logic [7:0] s;
    s = `FAS_ZERO8;
    s[`FAS_ST_BUSY] = busy;
    s[`FAS_ST_PROG] = prog;
    s[`FAS_ST_WIPE] = wipe;
    return s;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    ptr_nxt       = ptr_r;
    key_nxt       = key_r;
    op_nxt        = op_r;
    cnt_nxt       = cnt_r;
    op_addr_nxt   = op_addr_r;
    op_data_nxt   = op_data_r;
    last_prog_nxt = last_prog_r;
    last_wipe_nxt = last_wipe_r;
    lock_nxt      = lock_r;
    rdata_nxt     = `FAS_ZERO8;
    done_nxt      = 1'b0;
    mem_we        = 1'b0;
    mem_wa        = op_addr_r;
    mem_wd        = `FAS_ERASED;
    try_prog      = 1'b0;
    try_wipe      = 1'b0;
    cur_byte      = mem_r[ptr_r[`FAS_MEM_AW-1:0]];

    if (bus.rd) begin
      case (bus.addr)
        `FAS_REG_AUTORD: begin
          rdata_nxt = cur_byte;
          ptr_nxt   = ptr_r + `FAS_PTR_ONE;
        end
        `FAS_REG_BYTE: rdata_nxt = cur_byte;
        `FAS_REG_PTRL: rdata_nxt = ptr_r[7:0];
        `FAS_REG_PTRH: rdata_nxt = ptr_r[15:8];
        `FAS_REG_STAT: rdata_nxt = status_byte(op_r != OP_IDLE,
                                               last_prog_r, last_wipe_r);
        default: rdata_nxt = `FAS_ZERO8;
      endcase
    end

    if (bus.wr) begin
      case (bus.addr)
        `FAS_REG_KEY: begin
          if (key_r == KEY_HALF && bus.wdata == `FAS_KEY2) begin
            key_nxt = KEY_OPEN;
          end else if (bus.wdata == `FAS_KEY1) begin
            key_nxt = KEY_HALF;
          end else begin
            key_nxt = KEY_SHUT;
          end
        end
        `FAS_REG_PTRL: ptr_nxt[7:0]  = bus.wdata;
        `FAS_REG_PTRH: ptr_nxt[15:8] = bus.wdata;
        `FAS_REG_BYTE: try_prog = 1'b1;
        `FAS_REG_WIPE: try_wipe = bus.wdata[`FAS_GO_BIT];
        default: ;
      endcase
    end

    // a request while busy is ignored and keeps the key
    if ((try_prog || try_wipe) && op_r == OP_IDLE) begin
      key_nxt = KEY_SHUT;
      if (key_r == KEY_OPEN && !lock_r) begin
        op_nxt      = try_prog ? OP_PROG : OP_WIPE;
        cnt_nxt     = 17'h0_0000;
        op_addr_nxt = ptr_r[`FAS_MEM_AW-1:0];
        op_data_nxt = bus.wdata;
      end else begin
        lock_nxt = 1'b1;
      end
    end

    case (op_r)
      OP_PROG: begin
        cnt_nxt = cnt_r + 17'h0_0001;
        if (cnt_r == 17'(PROG_CYCLES - 1)) begin
          mem_we = 1'b1;
          // programming only clears bits
          mem_wd = mem_r[op_addr_r] & op_data_r;
          op_nxt = OP_IDLE;
          last_prog_nxt = 1'b1;
          last_wipe_nxt = 1'b0;
          done_nxt = 1'b1;
        end
      end
      OP_WIPE: begin
        cnt_nxt = cnt_r + 17'h0_0001;
        // one byte of the page per cycle
        if (cnt_r < `FAS_PAGE_BYTES) begin
          mem_we = 1'b1;
          mem_wa = {op_addr_r[`FAS_MEM_AW-1:`FAS_PAGE_AW],
                    cnt_r[`FAS_PAGE_AW-1:0]};
        end
        if (cnt_r == 17'(ERASE_CYCLES - 1)) begin
          op_nxt = OP_IDLE;
          last_prog_nxt = 1'b0;
          last_wipe_nxt = 1'b1;
          done_nxt = 1'b1;
        end
      end
      default: cnt_nxt = 17'h0_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ptr_r       <= 16'h0000;
      key_r       <= KEY_SHUT;
      op_r        <= OP_IDLE;
      cnt_r       <= 17'h0_0000;
      op_addr_r   <= 13'h0000;
      op_data_r   <= `FAS_ZERO8;
      last_prog_r <= 1'b0;
      last_wipe_r <= 1'b0;
      lock_r      <= 1'b0;
      rdata_r     <= `FAS_ZERO8;
      done_r      <= 1'b0;
    end else begin
      ptr_r       <= ptr_nxt;
      key_r       <= key_nxt;
      op_r        <= op_nxt;
      cnt_r       <= cnt_nxt;
      op_addr_r   <= op_addr_nxt;
      op_data_r   <= op_data_nxt;
      last_prog_r <= last_prog_nxt;
      last_wipe_r <= last_wipe_nxt;
      lock_r      <= lock_nxt;
      rdata_r     <= rdata_nxt;
      done_r      <= done_nxt;
    end
  end

  // non-volatile contents survive reset, so no reset branch here
  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      mem_r[mem_wa] <= mem_wd;
    end
  end

  assign bus.rdata          = rdata_r;
  assign bus.op_done        = done_r;
  assign nvm_op_in_progress = (op_r != OP_IDLE);
  assign nvm_locked_out     = lock_r;
endmodule
`default_nettype wire

// >>> verification/fas_sva.sv
`timescale 1ns/1ps
`default_nettype none
module fas_sva #(
  parameter int unsigned PROG_CYCLES  = 20,
  parameter int unsigned ERASE_CYCLES = 600
) (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_n,
  // device bus
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       op_done,
  // device status
  input wire logic       nvm_op_in_progress
);
  // ----------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------
  logic [19:0] run_r;
  logic [19:0] run_nxt;
  logic [7:0]  key_r;
  logic [7:0]  key_nxt;
  logic        go;

  // a request only counts as a start when the device is idle
  assign go = wr && !nvm_op_in_progress &&
              (addr == 8'h06 || (addr == 8'h6A && wdata[0]));

  always_comb begin
    run_nxt = nvm_op_in_progress ? run_r + 20'h0_0001 : 20'h0_0000;
    key_nxt = key_r;
    if (wr && addr == 8'h67) begin
      key_nxt = wdata;
    end else if (go) begin
      key_nxt = 8'h00;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      run_r <= 20'h0_0000;
      key_r <= 8'h00;
    end else begin
      run_r <= run_nxt;
      key_r <= key_nxt;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_go_prog;
    go && addr == 8'h06;
  endsequence
  sequence s_go_wipe;
    go && addr == 8'h6A;
  endsequence

  property p_rd_gap;
    rdata != 8'h00 |-> $past(rd);
  endproperty
  property p_done_pulse;
    op_done |=> !op_done;
  endproperty
  property p_done_busy;
    op_done |-> !nvm_op_in_progress && $past(nvm_op_in_progress);
  endproperty
  property p_prog_start;
    s_go_prog |=> nvm_op_in_progress [*8];
  endproperty
  property p_wipe_start;
    s_go_wipe |=> nvm_op_in_progress [*8];
  endproperty
  property p_run_len;
    op_done |-> run_r == 20'(PROG_CYCLES) || run_r == 20'(ERASE_CYCLES);
  endproperty
  property p_key_order;
    wr && addr == 8'h67 && wdata == 8'hF1 |-> key_r == 8'hA5;
  endproperty
  property p_one_unlock;
    go |-> key_r == 8'hF1;
  endproperty

  a_rd_gap:     assert property (p_rd_gap)
    else $error("read data outside answer cycle");
  a_done_pulse: assert property (p_done_pulse)
    else $error("completion pulse too long");
  a_done_busy:  assert property (p_done_busy)
    else $error("completion not at end of busy");
  a_prog_start: assert property (p_prog_start)
    else $error("program did not start");
  a_wipe_start: assert property (p_wipe_start)
    else $error("wipe did not start");
  a_run_len:    assert property (p_run_len)
    else $error("busy interval wrong length");
  a_key_order:  assert property (p_key_order)
    else $error("second code without first");
  a_one_unlock: assert property (p_one_unlock)
    else $error("operation without fresh unlock");
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic       clk_sys = 1'b0;
  logic       rst_n   = 1'b0;
  logic [3:0] u_addr  = 4'h0;
  logic [7:0] u_wdata = 8'h00;
  logic       u_wr    = 1'b0;
  logic       u_rd    = 1'b0;
  logic [7:0] u_rdata;
  logic       irq;
  logic       busy1;
  logic       busy2;
  logic       lock2;
  logic       lock1;
  logic [7:0] msk;
  int         err_count = 0;
  int         cmp_count = 0;
  // shortened intervals; the checker's defaults are the same
  localparam int unsigned PROG_CYC  = 20;
  localparam int unsigned ERASE_CYC = 600;

  always #50 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------
  // two ends, plus a rogue driver on a second device
  // ----------------------------------------------------------------
  fas_bus_if b_main ();
  fas_bus_if b_rogue ();
  fas_device #(.PROG_CYCLES(PROG_CYC), .ERASE_CYCLES(ERASE_CYC))
    i_fas_device (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus(b_main.dev),
    .nvm_op_in_progress(busy1), .nvm_locked_out(lock1));
  fas_host i_fas_host (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus(b_main.host), .u_addr(u_addr),
    .u_wdata(u_wdata), .u_wr(u_wr), .u_rd(u_rd), .u_rdata(u_rdata),
    .irq(irq));
  fas_device #(.PROG_CYCLES(PROG_CYC), .ERASE_CYCLES(ERASE_CYC))
    i_fas_device_b (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus(b_rogue.dev),
    .nvm_op_in_progress(busy2), .nvm_locked_out(lock2));
  fas_sva i_fas_sva (
    .clk_sys(clk_sys), .rst_n(rst_n), .addr(b_main.addr),
    .wdata(b_main.wdata), .wr(b_main.wr), .rd(b_main.rd),
    .rdata(b_main.rdata), .op_done(b_main.op_done),
    .nvm_op_in_progress(busy1));

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic uw(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    u_addr <= a;
    u_wdata <= d;
    u_wr <= 1'b1;
    @(posedge clk_sys);
    u_wr <= 1'b0;
  endtask
  task automatic ur(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    u_addr <= a;
    u_rd <= 1'b1;
    @(posedge clk_sys);
    u_rd <= 1'b0;
    #1 d = u_rdata;
  endtask
  task automatic dw(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    b_rogue.addr <= a;
    b_rogue.wdata <= d;
    b_rogue.wr <= 1'b1;
    @(posedge clk_sys);
    b_rogue.wr <= 1'b0;
  endtask
  task automatic dchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    b_rogue.addr <= a;
    b_rogue.rd <= 1'b1;
    @(posedge clk_sys);
    b_rogue.rd <= 1'b0;
    #1 `CHK(b_rogue.rdata, e)
  endtask
  task automatic wdone;
    int n;
    for (n = 0; n < 2000 && b_rogue.op_done !== 1'b1; n++) begin
      @(posedge clk_sys);
      #1;
    end
    `CHK(b_rogue.op_done, 1'b1)
  endtask

  // issue a host command, wait for its event bit, check irq, clear
  task automatic hop(input logic [1:0] c, input logic [15:0] p,
                     input logic [7:0] d, input int b);
    logic [7:0] v;
    int         n;
    uw(4'h1, p[7:0]);
    uw(4'h2, p[15:8]);
    uw(4'h3, d);
    uw(4'h0, {6'h00, c});
    ur(4'h4, v);
    `CHK(v, 8'h01)
    v = 8'h00;
    for (n = 0; n < 2000 && v[b] !== 1'b1; n++) begin
      ur(4'h5, v);
    end
    `CHK(v[b], 1'b1)
    #1 `CHK(irq, |(v[2:0] & msk[2:0]))
    uw(4'h5, 8'h07);
    #1 `CHK(irq, 1'b0)
    ur(4'h4, v);
    `CHK(v, 8'h00)
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_wipe;
    logic [7:0] v;
    ur(4'h5, v);
    `CHK(v, 8'h00)
    msk = 8'h01;
    uw(4'h6, msk);
    hop(2'h3, 16'h0234, 8'h00, 0);
    hop(2'h0, 16'h0200, 8'h00, 1);
    ur(4'h3, v);
    `CHK(v, 8'hFF)
    hop(2'h0, 16'h03FF, 8'h00, 1);
    ur(4'h3, v);
    `CHK(v, 8'hFF)
    $display("test wipe done");
  endtask

  task automatic t_prog;
    logic [7:0] v;
    msk = 8'h00;
    uw(4'h6, msk);
    hop(2'h2, 16'h0210, 8'h5A, 0);
    hop(2'h2, 16'h0211, 8'h3C, 0);
    hop(2'h2, 16'h0210, 8'h00, 2);
    hop(2'h0, 16'h0210, 8'h00, 1);
    ur(4'h3, v);
    `CHK(v, 8'h5A)
    hop(2'h0, 16'h0211, 8'h00, 1);
    ur(4'h3, v);
    `CHK(v, 8'h3C)
    `CHK(lock1, 1'b0)
    $display("test program done");
  endtask

  task automatic t_seq;
    logic [7:0] v;
    logic [7:0] exp_q [3];
    exp_q = '{8'h5A, 8'h3C, 8'hFF};
    msk = 8'h02;
    uw(4'h6, msk);
    hop(2'h0, 16'h0210, 8'h00, 1);
    for (int i = 0; i < 3; i++) begin
      hop(2'h1, 16'h0000, 8'h00, 1);
      ur(4'h3, v);
      `CHK(v, exp_q[i])
    end
    $display("test sequential done");
  endtask

  task automatic t_dev;
    dw(8'h68, 8'h34);
    dw(8'h69, 8'h02);
    dchk(8'h68, 8'h34);
    dchk(8'h69, 8'h02);
    dw(8'h67, 8'hA5);
    dchk(8'h67, 8'h00);
    dw(8'h67, 8'hF1);
    dw(8'h6A, 8'h01);
    dchk(8'h7B, 8'h08);
    dchk(8'h6A, 8'h00);
    wdone();
    dchk(8'h7B, 8'h01);
    dw(8'h67, 8'hA5);
    dw(8'h67, 8'hF1);
    dw(8'h06, 8'h81);
    wdone();
    dchk(8'h7B, 8'h02);
    dchk(8'h06, 8'h81);
    dchk(8'h06, 8'h81);
    dchk(8'h05, 8'h81);
    dchk(8'h05, 8'hFF);
    dchk(8'h68, 8'h36);
    // data write with no unlock in front of it
    dw(8'h06, 8'h00);
    #1 `CHK(lock2, 1'b1)
    dw(8'h67, 8'hA5);
    dw(8'h67, 8'hF1);
    dw(8'h6A, 8'h01);
    @(posedge clk_sys);
    #1 `CHK(busy2, 1'b0)
    dchk(8'h10, 8'h00);
    // only a reset lifts the lockout
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1 `CHK(lock2, 1'b0)
    dw(8'h67, 8'hA5);
    dw(8'h67, 8'hF1);
    dw(8'h6A, 8'h01);
    @(posedge clk_sys);
    #1 `CHK(busy2, 1'b1)
    $display("test rogue device done");
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    b_rogue.addr = 8'h00;
    b_rogue.wdata = 8'h00;
    b_rogue.wr = 1'b0;
    b_rogue.rd = 1'b0;
    msk = 8'h00;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_wipe();
    t_prog();
    t_seq();
    t_dev();
    final_report();
  end

  // the tests need well under 10000 cycles
  initial begin
    #(100 * 30000);
    err_count++;
    final_report();
  end
endmodule
`default_nettype wire
